/* ldim_pkg.sv */
// Purpose: Shared constants for the LED channel dimming register block.
// Assumes: Registers are reached by a simple internal write/read port.
// Notes:   Offsets are byte addresses within the device register space.
package ldim_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          REG_W         = 13;
  localparam int          DUTY_W        = 12;
  localparam int          NUM_CH        = 3;
  localparam int          FADE_BIT      = 12;
  localparam int          DUTY_MSB      = 11;
  localparam logic [7:0]  OFS_LED9      = 8'h4A;
  localparam logic [7:0]  OFS_LED10     = 8'h4B;
  localparam logic [7:0]  OFS_LED11     = 8'h4C;
  localparam logic [12:0] RST_SETTING   = 13'h0000;
  localparam logic [11:0] DUTY_OFF      = 12'h000;
  localparam logic [11:0] DUTY_FULL     = 12'hFFF;
  localparam logic [11:0] PERIOD_LAST   = 12'hFFE;
endpackage

/* ldim_pwm_chan.sv */
// Purpose: One bypass-switch dimming comparator.
// Assumes: Phase counter runs 0 to 4094, 4095 steps per period.
// Notes:   Output registered; switch open means LED lit.
`timescale 1ns/100ps
module ldim_pwm_chan (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst_n,
  input  wire logic [ldim_pkg::DUTY_W-1:0] i_duty,
  input  wire logic [ldim_pkg::DUTY_W-1:0] i_phase,
  output logic                            o_switch_open
);
  import ldim_pkg::*;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_switch_open <= 1'b0;
    end else begin
      o_switch_open <= (i_phase < i_duty); // R2 R3 R7
    end
  end
endmodule

/* ldim_regs.sv */
// Purpose: Dimming setting registers for LED channels 9 to 11 and their switch drive.
// Assumes: Register port writes and reads are synchronous to i_clock.
// Notes:   Fade select is passed to the fade logic outside this block.
// How it works
// R1: Register at 0x4B holds LED10 twelve-bit duty in bits 11:0, read and write.
// R2: Duty 0x000 keeps LED off; 0x001 lights one part in 4095.
// R3: Duty 0xFFF lights the whole period; other codes scale linearly.
// R4: Bit 12 selects fade: 0 fades, 1 disables; resets to 0.
// R5: Register at 0x4C holds LED11 duty and fade select, read and write.
// R6: Register at 0x4A holds LED9 duty and fade with the same layout.
// R7: Bypass switch open for the programmed fraction, closed otherwise.
`timescale 1ns/100ps
module ldim_regs (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_en,
  input  wire logic [ldim_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ldim_pkg::REG_W-1:0]  i_wdata,
  output logic      [ldim_pkg::REG_W-1:0]  o_rdata,
  output logic                             o_rd_hit,
  output logic      [ldim_pkg::NUM_CH-1:0] o_switch_open,
  output logic      [ldim_pkg::NUM_CH-1:0] o_fade_disable,
  output logic      [ldim_pkg::DUTY_W-1:0] o_phase
);
  import ldim_pkg::*;

  logic [REG_W-1:0]  setting [NUM_CH];
  logic [ADDR_W-1:0] ch_ofs  [NUM_CH];
  logic [NUM_CH-1:0] hit;
  logic [REG_W-1:0]  next_rdata;
  logic [1:0]        wr_hist [NUM_CH];
  logic [NUM_CH-1:0] steady;
  logic [DUTY_W-1:0] lit_cnt [NUM_CH];
  logic [DUTY_W-1:0] period_cnt;

  assign ch_ofs[0] = OFS_LED9;  // R6
  assign ch_ofs[1] = OFS_LED10; // R1
  assign ch_ofs[2] = OFS_LED11; // R5

  // Shared dimming period: 4095 phase steps so that 0xFFF means always lit.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase <= DUTY_OFF;
    end else if (o_phase == PERIOD_LAST) begin
      o_phase <= DUTY_OFF; // R3
    end else begin
      o_phase <= o_phase + 12'h001;
    end
  end

  // Clocks since the phase was last seen at zero, an independent measure of the period.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_cnt <= DUTY_OFF;
    end else if (o_phase == DUTY_OFF) begin
      period_cnt <= DUTY_OFF;
    end else begin
      period_cnt <= period_cnt + 12'h001;
    end
  end

  period_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    (o_phase == DUTY_OFF) && $past(i_rst_n)
    |-> (period_cnt == PERIOD_LAST))
    else $error("Dimming period is not 4095 clocks.");

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign hit[g] = (i_addr == ch_ofs[g]);

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          setting[g] <= RST_SETTING; // R4
        end else if (i_wr_en && hit[g]) begin
          setting[g] <= i_wdata; // R1 R4 R5 R6
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_fade_disable[g] <= 1'b0;
        end else begin
          o_fade_disable[g] <= setting[g][FADE_BIT]; // R4
        end
      end

      ldim_pwm_chan u_chan (
        .i_clock       (i_clock),
        .i_rst_n       (i_rst_n),
        .i_duty        (setting[g][DUTY_MSB:0]),
        .i_phase       (o_phase),
        .o_switch_open (o_switch_open[g])
      );

      lit_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
        ($past(setting[g][DUTY_MSB:0]) == DUTY_OFF) |-> !o_switch_open[g])
        else $error("LED lit with zero duty.");
      lit_full_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
        ($past(setting[g][DUTY_MSB:0]) == DUTY_FULL) && $past(i_rst_n) |-> o_switch_open[g])
        else $error("LED not lit with full duty.");
      lit_window_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R7
        $past(i_rst_n) |-> (o_switch_open[g] == ($past(o_phase) < $past(setting[g][DUTY_MSB:0]))))
        else $error("Switch state does not match phase against duty.");
      write_store_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
        (i_wr_en && hit[g]) |=> (setting[g] == $past(i_wdata)))
        else $error("Write did not store setting.");
      fade_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
        (i_wr_en && hit[g]) |=> ##1 (o_fade_disable[g] == $past(i_wdata[FADE_BIT], 2)))
        else $error("Fade select does not follow write.");
      setting_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
        !(i_wr_en && hit[g])
        |=> $stable(setting[g]))
        else $error("Setting changed without a write to it.");
      fade_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
        !(i_wr_en && hit[g])
        |=> ##1 $stable(o_fade_disable[g]))
        else $error("Fade select changed without a write.");
      lit_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
        ($past(setting[g][DUTY_MSB:0]) == 12'h001) && $past(i_rst_n)
        |-> (o_switch_open[g] == ($past(o_phase) == DUTY_OFF)))
        else $error("Duty one not lit for exactly one step.");

      // Writes taken at the last two edges, which may still reach the switch output.
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          wr_hist[g] <= 2'h0;
        end else begin
          wr_hist[g] <= {wr_hist[g][0], i_wr_en && hit[g]};
        end
      end

      // A period is judged only when no write could have reached the switch inside it.
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          steady[g] <= 1'b0;
        end else if (o_phase == 12'h001) begin
          steady[g] <= (wr_hist[g] == 2'h0) && !(i_wr_en && hit[g]);
        end else if (i_wr_en && hit[g]) begin
          steady[g] <= 1'b0;
        end
      end

      // Lit steps of the period whose last step is seen while the phase shows zero.
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lit_cnt[g] <= DUTY_OFF;
        end else if (o_phase == 12'h001) begin
          lit_cnt[g] <= {11'h000, o_switch_open[g]};
        end else begin
          lit_cnt[g] <= lit_cnt[g] + {11'h000, o_switch_open[g]};
        end
      end

      lit_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
        (o_phase == DUTY_OFF) && steady[g]
        |-> ((lit_cnt[g] + {11'h000, o_switch_open[g]}) == setting[g][DUTY_MSB:0]))
        else $error("Lit steps per period differ from duty.");
    end
  endgenerate

  always_comb begin
    next_rdata = '0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (hit[k]) begin
        next_rdata = setting[k];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata  <= RST_SETTING;
      o_rd_hit <= 1'b0;
    end else begin
      o_rdata  <= i_rd_en ? next_rdata : RST_SETTING; // R1 R5 R6
      o_rd_hit <= i_rd_en && (|hit);
    end
  end

  read_back_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R5
    (i_rd_en && !i_wr_en && i_addr == OFS_LED11) |=> (o_rd_hit && o_rdata == setting[2]))
    else $error("Read of LED11 setting wrong.");
  phase_wrap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    (o_phase == PERIOD_LAST) |=> (o_phase == DUTY_OFF))
    else $error("Dimming period length wrong.");
  map_nine_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R6
    (i_rd_en && !i_wr_en && i_addr == OFS_LED9) |=> (o_rdata == setting[0]))
    else $error("Read of LED9 setting wrong.");

  // The read port answers once, one clock after the strobe, and reads as zero otherwise.
  read_ten_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
    (i_rd_en && !i_wr_en && i_addr == OFS_LED10)
    |=> (o_rd_hit && o_rdata == setting[1]))
    else $error("Read of LED10 setting wrong.");
  read_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
    !i_rd_en
    |=> (!o_rd_hit && o_rdata == RST_SETTING))
    else $error("Read port active without a read.");
  read_miss_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
    (i_rd_en && !(|hit))
    |=> (!o_rd_hit && o_rdata == RST_SETTING))
    else $error("Read of unmapped offset returned data.");

  // The shared phase climbs by one each clock up to 0xFFE, then wraps to zero, and never reaches the all-ones code.
  phase_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    (o_phase != PERIOD_LAST)
    |=> (o_phase == $past(o_phase) + 12'h001))
    else $error("Dimming phase skipped a step.");
  phase_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    o_phase <= PERIOD_LAST)
    else $error("Dimming phase beyond last step.");
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the LED dimming setting registers.
// Assumes: Strobed register port, read data registered at the same edge that takes the strobe.
// Notes:   Lit time is counted over one full 4095-clock dimming period.
`timescale 1ns/100ps
module testbench;
  import ldim_pkg::*;
  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              i_wr_en = 1'b0;
  logic              i_rd_en = 1'b0;
  logic [ADDR_W-1:0] i_addr  = 8'h00;
  logic [REG_W-1:0]  i_wdata = 13'h0000;
  logic [REG_W-1:0]  o_rdata;
  logic              o_rd_hit;
  logic [NUM_CH-1:0] o_switch_open;
  logic [NUM_CH-1:0] o_fade_disable;
  logic [DUTY_W-1:0] o_phase;
  int                error_cnt   = 0;
  int                check_count = 0;
  int                cyc         = 0;
  logic [33:0]       rows [4] = '{{8'h4A, 13'h1001, 13'h1001}, {8'h4B, 13'h0FFF, 13'h0FFF},
                                  {8'h4C, 13'h1000, 13'h1000}, {8'h4D, 13'h1FFF, 13'h0000}};
  ldim_regs DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit),
    .o_switch_open(o_switch_open), .o_fade_disable(o_fade_disable), .o_phase(o_phase));
  always #2.5 i_clock = ~i_clock;
  task final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      final_report;
    end
  end
  task chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; returns 1 ns after the edge that takes the strobe, with the answer settled.
  task acc(input logic w, input logic [7:0] a, input logic [12:0] d);
    @(posedge i_clock);
    i_wr_en <= w;
    i_rd_en <= !w;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b0;
    #1;
  endtask
  task automatic count(input int e0, input int e1, input int e2);
    int                c[3] = '{0, 0, 0};
    logic [DUTY_W-1:0] p;
    logic [DUTY_W-1:0] mx;
    @(posedge i_clock);
    #1;
    p  = o_phase;
    mx = 12'h000;
    repeat (4095) begin
      for (int k = 0; k < 3; k++) c[k] += int'(o_switch_open[k]);
      if (o_phase > mx) mx = o_phase;
      @(posedge i_clock);
      #1;
    end
    chk(13'(c[0]), 13'(e0));
    chk(13'(c[1]), 13'(e1));
    chk(13'(c[2]), 13'(e2));
    chk(13'(o_phase), 13'(p));
    chk(13'(mx), 13'(PERIOD_LAST));
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    count(0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, rows[i][33:26], 13'h0000);
      chk(o_rdata, 13'h0000);
      acc(1'b1, rows[i][33:26], rows[i][25:13]);
      acc(1'b0, rows[i][33:26], 13'h0000);
      chk(o_rdata, rows[i][12:0]);
      chk(13'(o_rd_hit), 13'(i < 3));
    end
    chk(13'(o_fade_disable), 13'h0005);
    acc(1'b1, OFS_LED9, 13'h0001);
    acc(1'b1, OFS_LED10, 13'h0800);
    acc(1'b1, OFS_LED11, 13'h1FFF);
    @(posedge i_clock);
    count(1, 2048, 4095);
    chk(13'(o_fade_disable), 13'h0004);
    // Reset in mid-run must clear the phase, the switches and the LED11 setting.
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(13'({o_fade_disable, o_switch_open}), 13'h0000);
    chk(13'(o_phase), 13'h0000);
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    acc(1'b0, OFS_LED11, 13'h0000);
    chk(o_rdata, 13'h0000);
    final_report;
  end
endmodule
